// ### hw/serial_port_defs.vh
// Constants for the timer-paced asynchronous serial port
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// Register addresses on the special-register port
`define CTRL_ADDR 8'h98
`define DATA_ADDR 8'h99

// Control register reset value and field positions
`define CTRL_RESET 8'h00
`define CTRL_MODE_BIT 7
`define CTRL_UNUSED_BIT 6
`define CTRL_CHECK_BIT 5
`define CTRL_REN_BIT 4
`define CTRL_TB8_BIT 3
`define CTRL_RB8_BIT 2
`define CTRL_TI_BIT 1
`define CTRL_RI_BIT 0

// Baud timer input clock selections
`define CLKSEL_DIV1 3'h0
`define CLKSEL_DIV4 3'h1
`define CLKSEL_DIV12 3'h2
`define CLKSEL_DIV48 3'h3
`define CLKSEL_EXT8 3'h4

// Prescaler terminal counts
`define PRE_LAST 6'h2f
`define PRE_DIV4_MASK 2'h3
`define PRE_DIV12_LAST 4'hb
`define EXT_LAST 3'h7

// Timer overflow point
`define TIMER_TOP 8'hff

// Frame lengths in bit times and buffer depth
`define FRAME_BITS_8 4'ha
`define FRAME_BITS_9 4'hb
`define TX_FIFO_DEPTH 8

`endif

// ### hw/serial_port.v
// Timer-paced serial port with transmit FIFO and register port
`timescale 1ns/1ns
`include "serial_port_defs.vh"

// Small synchronous FIFO with registered ready and valid
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Filling side
  input wire in_valid,
  output reg in_ready_r,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output reg out_valid_r,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
  reg [AW-1:0] wr_ptr_r; // Next slot to write
  reg [AW-1:0] rd_ptr_r; // Next slot to read
  reg [AW:0] count_r; // Words held
  reg [AW:0] count_nxt;
  wire push = in_valid & in_ready_r; // Accepted write
  wire pop = out_valid_r & out_ready; // Accepted read

  assign out_data = mem[rd_ptr_r];

  // Occupancy after this cycle
  always @* begin
    count_nxt = count_r;
    if (push & ~pop) begin
      count_nxt = count_r + {{AW{1'b0}}, 1'b1};
    end else if (pop & ~push) begin
      count_nxt = count_r - {{AW{1'b0}}, 1'b1};
    end
  end

  // Pointers and flags; flags are flops so they never glitch
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      in_ready_r <= 1'b1;
      out_valid_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      count_r <= count_nxt;
      in_ready_r <= (count_nxt != DEPTH[AW:0]);
      out_valid_r <= (count_nxt != {(AW+1){1'b0}});
    end
  end

  // Data array has no reset, so it stays plain storage
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
endmodule

// Summary of operation
// - Data read gives received byte, write transmits
// - Receiver shifts new byte while buffer unread
// - Enabled interrupt on either done flag
// - Done flags cleared only by software
// - Transmit clock from 8-bit auto-reload overflows
// - Hidden receive timer mirrors baud timer
// - Start edge reloads receive timer immediately
// - Both timer overflows divided by two
// - Rate is clock/(256-reload)/2
// - Five selectable timer input clocks
// - Control bit 7 selects 8/9-bit frames
// - 8-bit frame: start, eight LSB-first, stop
// - Writing data buffer starts transmission
// - Transmit-done set at start of stop bit
// - Control bit 4 enables reception
// - Accept only if flag clear, stop checked in 8-bit with bit 5
// - Acceptance stores byte, bit 2, sets flag
// - Overrun keeps first byte, drops later
// - 9-bit filter: flag only when ninth bit 1
// - Bit 3 sent ninth; ninth received to bit 2
// - Receive-done set at stop sample
// - Control bit 6 reads one, ignores writes
module serial_port (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Special-register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_r,
  // Baud timer controls
  input wire timer_run,
  input wire [2:0] timer_clk_sel,
  input wire ext_osc_tick,
  input wire [7:0] baud_reload_value,
  // Interrupt
  input wire port_int_enable,
  output reg port_irq_r,
  // Serial lines
  input wire rx_pin,
  output reg tx_pin_r,
  // Transmit buffer space
  output wire tx_buf_ready
);
  // Control register fields
  reg frame_format_select_r; // 0: 8-bit, 1: 9-bit
  reg stop_check_or_address_filter_r;
  reg receiver_enable_bit_r;
  reg tx_ninth_bit_r;
  reg rx_ninth_bit_r;
  reg tx_done_flag_r;
  reg rx_done_flag_r;
  reg [7:0] rx_buffer_r; // Buffered received byte
  // Baud timers
  reg [5:0] pre_r; // System clock prescaler
  reg [3:0] pre12_r; // Divide-by-12 counter
  reg [2:0] ext_r; // External oscillator divider
  reg timer_tick; // Baud timer input clock enable
  reg [7:0] baud_timer_low_byte_r; // Transmit timer
  reg [7:0] rx_timer_r; // Hidden receive copy
  reg tx_div_r;
  reg rx_div_r;
  wire tx_ovf;
  wire rx_ovf;
  wire tx_bit;
  wire rx_sample;
  // Transmitter
  reg tx_busy_r;
  reg [10:0] tx_sh_r;
  reg [3:0] tx_cnt_r;
  reg [3:0] tx_len_r;
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire tx_load = fifo_valid & ~tx_busy_r; // Idle shifter takes a word
  wire data_wr = sfr_wr & (sfr_addr == `DATA_ADDR);
  wire ctrl_wr = sfr_wr & (sfr_addr == `CTRL_ADDR);
  // Receiver
  reg rx_prev_r;
  reg rx_busy_r;
  reg [3:0] rx_idx_r;
  reg [7:0] rx_sh_r; // Shift path, separate from buffer
  reg rx_nine_r;
  wire start_det;
  wire [3:0] rx_last;
  wire rx_stop;
  wire rx_accept;
  wire rx_set;
  wire tx_set;

  // Transmit words queue here; writes while full are dropped
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(`TX_FIFO_DEPTH),
    .AW(3)
  ) tx_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(data_wr),
    .in_ready_r(tx_buf_ready),
    .in_data(sfr_wdata),
    .out_valid_r(fifo_valid),
    .out_ready(tx_load),
    .out_data(fifo_data)
  );

  // Timer input clock select
  always @* begin
    case (timer_clk_sel)
      `CLKSEL_DIV1: timer_tick = 1'b1;
      `CLKSEL_DIV4: timer_tick = (pre_r[1:0] == `PRE_DIV4_MASK);
      `CLKSEL_DIV12: timer_tick = (pre12_r == `PRE_DIV12_LAST);
      `CLKSEL_DIV48: timer_tick = (pre_r == `PRE_LAST);
      `CLKSEL_EXT8: timer_tick = ext_osc_tick & (ext_r == `EXT_LAST);
      default: timer_tick = 1'b0; // Reserved codes stop the timer
    endcase
  end

  // Prescalers run freely so a select change takes effect at once
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= 6'h00;
      pre12_r <= 4'h0;
      ext_r <= 3'h0;
    end else begin
      pre_r <= (pre_r == `PRE_LAST) ? 6'h00 : pre_r + 6'h01;
      pre12_r <= (pre12_r == `PRE_DIV12_LAST) ? 4'h0 : pre12_r + 4'h1;
      if (ext_osc_tick) begin
        ext_r <= ext_r + 3'h1;
      end
    end
  end

  assign tx_ovf = timer_run & timer_tick &
                  (baud_timer_low_byte_r == `TIMER_TOP);
  assign rx_ovf = timer_run & timer_tick & (rx_timer_r == `TIMER_TOP);
  assign tx_bit = tx_ovf & tx_div_r;
  // Odd overflows after the start edge fall mid-bit
  assign rx_sample = rx_ovf & ~rx_div_r & rx_busy_r;
  assign start_det = ~rx_busy_r & receiver_enable_bit_r &
                     rx_prev_r & ~rx_pin;

  // Transmit and receive auto-reload timers
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_timer_low_byte_r <= 8'h00;
      rx_timer_r <= 8'h00;
      tx_div_r <= 1'b0;
      rx_div_r <= 1'b0;
    end else begin
      if (tx_ovf) begin
        baud_timer_low_byte_r <= baud_reload_value;
        tx_div_r <= ~tx_div_r;
      end else if (timer_run & timer_tick) begin
        baud_timer_low_byte_r <= baud_timer_low_byte_r + 8'h01;
      end
      if (start_det) begin
        rx_timer_r <= baud_reload_value;
        rx_div_r <= 1'b0;
      end else if (rx_ovf) begin
        rx_timer_r <= baud_reload_value;
        rx_div_r <= ~rx_div_r;
      end else if (timer_run & timer_tick) begin
        rx_timer_r <= rx_timer_r + 8'h01;
      end
    end
  end

  // Transmit shifter; frame waits for the next bit tick
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_busy_r <= 1'b0;
      tx_sh_r <= 11'h7ff;
      tx_cnt_r <= 4'h0;
      tx_len_r <= `FRAME_BITS_8;
      tx_pin_r <= 1'b1;
    end else if (tx_load) begin
      tx_busy_r <= 1'b1;
      tx_cnt_r <= 4'h0;
      if (frame_format_select_r) begin
        tx_sh_r <= {1'b1, tx_ninth_bit_r, fifo_data, 1'b0};
        tx_len_r <= `FRAME_BITS_9;
      end else begin
        tx_sh_r <= {2'b11, fifo_data, 1'b0};
        tx_len_r <= `FRAME_BITS_8;
      end
    end else if (tx_busy_r & tx_bit) begin
      if (tx_cnt_r == tx_len_r) begin
        tx_busy_r <= 1'b0; // Stop bit done, line stays high
      end else begin
        tx_pin_r <= tx_sh_r[0]; // LSB first
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_cnt_r <= tx_cnt_r + 4'h1;
      end
    end
  end

  // Stop bit goes out when the count hits its last slot
  assign tx_set = tx_busy_r & tx_bit &
                  (tx_cnt_r == tx_len_r - 4'h1);

  assign rx_last = frame_format_select_r ? `FRAME_BITS_9 - 4'h1 :
                   `FRAME_BITS_8 - 4'h1;
  assign rx_stop = rx_sample & (rx_idx_r == rx_last);
  // Flag clear is required; the check bit means stop or ninth bit
  assign rx_accept = ~rx_done_flag_r &
                     (~stop_check_or_address_filter_r |
                      (frame_format_select_r ? rx_nine_r : rx_pin));
  assign rx_set = rx_stop & rx_accept;

  // Receive shifter runs independent of the buffer
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_prev_r <= 1'b1;
      rx_busy_r <= 1'b0;
      rx_idx_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_nine_r <= 1'b0;
    end else begin
      rx_prev_r <= rx_pin;
      if (start_det) begin
        rx_busy_r <= 1'b1;
        rx_idx_r <= 4'h0;
      end else if (rx_sample) begin
        rx_idx_r <= rx_idx_r + 4'h1;
        if (rx_idx_r == 4'h0 && rx_pin) begin
          rx_busy_r <= 1'b0; // Glitch, not a real start
        end else if (rx_idx_r == rx_last) begin
          rx_busy_r <= 1'b0;
        end else if (rx_idx_r <= 4'h8 && rx_idx_r != 4'h0) begin
          rx_sh_r <= {rx_pin, rx_sh_r[7:1]};
        end else if (rx_idx_r == 4'h9) begin
          rx_nine_r <= rx_pin;
        end
      end
    end
  end

  // Control register, buffer and flags; hardware set beats clear
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_format_select_r <= 1'b0;
      stop_check_or_address_filter_r <= 1'b0;
      receiver_enable_bit_r <= 1'b0;
      tx_ninth_bit_r <= 1'b0;
      rx_ninth_bit_r <= 1'b0;
      tx_done_flag_r <= 1'b0;
      rx_done_flag_r <= 1'b0;
      rx_buffer_r <= 8'h00;
    end else begin
      if (ctrl_wr) begin
        frame_format_select_r <= sfr_wdata[`CTRL_MODE_BIT];
        stop_check_or_address_filter_r <= sfr_wdata[`CTRL_CHECK_BIT];
        receiver_enable_bit_r <= sfr_wdata[`CTRL_REN_BIT];
        tx_ninth_bit_r <= sfr_wdata[`CTRL_TB8_BIT];
        rx_ninth_bit_r <= sfr_wdata[`CTRL_RB8_BIT];
        tx_done_flag_r <= sfr_wdata[`CTRL_TI_BIT];
        rx_done_flag_r <= sfr_wdata[`CTRL_RI_BIT];
      end
      if (tx_set) begin
        tx_done_flag_r <= 1'b1;
      end
      if (rx_set) begin
        rx_buffer_r <= rx_sh_r;
        rx_ninth_bit_r <= frame_format_select_r ? rx_nine_r : rx_pin;
        rx_done_flag_r <= 1'b1;
      end
    end
  end

  // Registered read data and interrupt request
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata_r <= 8'h00;
      port_irq_r <= 1'b0;
    end else begin
      // Level follows flags; no vector clears them
      port_irq_r <= port_int_enable &
                    (tx_done_flag_r | rx_done_flag_r);
      if (sfr_rd && sfr_addr == `DATA_ADDR) begin
        sfr_rdata_r <= rx_buffer_r;
      end else if (sfr_rd && sfr_addr == `CTRL_ADDR) begin
        sfr_rdata_r <= {frame_format_select_r, 1'b1,
                        stop_check_or_address_filter_r,
                        receiver_enable_bit_r, tx_ninth_bit_r,
                        rx_ninth_bit_r, tx_done_flag_r, rx_done_flag_r};
      end else if (sfr_rd) begin
        sfr_rdata_r <= 8'h00; // Unmapped address
      end
    end
  end
endmodule

// ### tb/serial_port_chk.sv
// Port-level assertions for the serial port
`timescale 1ns/1ns
module serial_port_chk (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_r,
  // Timer, interrupt, serial
  input wire timer_run,
  input wire port_int_enable,
  input wire port_irq_r,
  input wire tx_pin_r,
  input wire tx_buf_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  reg [7:0] ctrl_wr_r; // Last byte written to control
  // Track control writes for readback
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      ctrl_wr_r <= 8'h00;
    else if (sfr_wr && sfr_addr == 8'h98)
      ctrl_wr_r <= sfr_wdata;
  end
  chk_irq_enable: assert property (
    port_irq_r |-> $past(port_int_enable))
    else $error("irq raised without enable");
  chk_tx_frozen: assert property (
    !timer_run && $past(!timer_run) && $past(!timer_run, 2)
      |-> $stable(tx_pin_r))
    else $error("tx moved with timer stopped");
  chk_rdata_hold: assert property (
    !$past(sfr_rd) |-> $stable(sfr_rdata_r))
    else $error("read data moved without read");
  chk_unmapped_zero: assert property (
    sfr_rd && sfr_addr != 8'h98 && sfr_addr != 8'h99
      |=> sfr_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  chk_unused_one: assert property (
    sfr_rd && sfr_addr == 8'h98 |=> sfr_rdata_r[6])
    else $error("control bit 6 not one");
  chk_ctrl_write: assert property (
    sfr_rd && !sfr_wr && sfr_addr == 8'h98 |=>
      sfr_rdata_r[7:3] == {ctrl_wr_r[7], 1'b1, ctrl_wr_r[5:3]})
    else $error("control readback wrong");
  chk_full_cause: assert property (
    $fell(tx_buf_ready) |-> $past(sfr_wr && sfr_addr == 8'h99))
    else $error("buffer full without data write");
  chk_start_width: assert property (
    $fell(tx_pin_r) |=> !tx_pin_r)
    else $error("start bit too short");
  cover property ($rose(port_irq_r));
  cover property ($fell(tx_buf_ready));
  cover property ($fell(tx_pin_r));
endmodule

// ### tb/remote_uart.sv
// Far-end serial transceiver model
`timescale 1ns/1ns
module remote_uart #(
  parameter BIT_CYC = 8
) (
  // Clock and frame format
  input wire ref_clk,
  input wire nine,
  // Line from the port and line to the port
  input wire line_in,
  output reg line_out
);
  logic [8:0] got_q[$]; // Frames heard, ninth bit on top
  initial line_out = 1'b1;
  // Send a frame; the stop level is the caller's to break
  task automatic send(input logic [8:0] w, input logic stop);
    int i;
    @(negedge ref_clk);
    line_out = 1'b0;
    repeat (BIT_CYC) @(negedge ref_clk);
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      line_out = w[i];
      repeat (BIT_CYC) @(negedge ref_clk);
    end
    line_out = stop;
    repeat (BIT_CYC) @(negedge ref_clk);
    line_out = 1'b1;
  endtask
  // Sample each frame from the port at mid-bit
  always @(negedge line_in) begin : rcv
    logic [8:0] w;
    int i;
    w = 9'h000;
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (BIT_CYC) @(posedge ref_clk);
      w[i] = line_in;
    end
    repeat (BIT_CYC) @(posedge ref_clk);
    if (line_in === 1'b1)
      got_q.push_back(w);
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the serial port
`timescale 1ns/1ns
module testbench;
  reg ref_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [7:0] sfr_addr = 8'h00;
  reg sfr_wr = 1'b0;
  reg sfr_rd = 1'b0;
  reg [7:0] sfr_wdata = 8'h00;
  reg timer_run = 1'b0;
  reg [2:0] clk_sel = 3'h0; // Undivided: bit time is 8 cycles
  reg nine = 1'b0;
  reg [7:0] reload = 8'hfc; // Timer reload byte
  reg irq_en = 1'b1; // Interrupt enable
  reg ext_tick = 1'b0; // External oscillator edge pulse
  wire [7:0] rdata;
  wire irq, tx, rx, rdy;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  int i;
  logic [7:0] v, b0;
  logic [8:0] w;
  logic [7:0] exp_q[$]; // Bytes the model expects on the line
  always #4 ref_clk = ~ref_clk;
  // External oscillator edge on every other cycle
  always @(negedge ref_clk) ext_tick <= ~ext_tick;
  serial_port dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_r(rdata),
    .timer_run(timer_run), .timer_clk_sel(clk_sel),
    .ext_osc_tick(ext_tick), .baud_reload_value(reload),
    .port_int_enable(irq_en), .port_irq_r(irq), .rx_pin(rx),
    .tx_pin_r(tx), .tx_buf_ready(rdy));
  remote_uart peer (.ref_clk(ref_clk), .nine(nine), .line_in(tx),
    .line_out(rx));
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      print_verdict;
    end
  end
  task cmp(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", what, e, g);
    end
  endtask
  // Cycle counts; counters are bench ints, never unknown
  task cmp_n(input string what, input int e, input int g);
    checks_done++;
    if (g != e) begin
      err_total++;
      $display("unexpected %s exp %0d got %0d", what, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    d = rdata;
  endtask
  // Wait, bounded, for k frames at the far end
  task heard(input int k);
    for (i = 0; i < 3000 && peer.got_q.size() < k; i++)
      @(posedge ref_clk);
    cmp("frame count", 8'(k), 8'(peer.got_q.size()));
  endtask
  // One start bit under a timer input choice; d0 set ends it cleanly
  task bit_time(input logic [2:0] sel, input int div);
    int k;
    int e;
    clk_sel = sel;
    reload = 8'hfc | 8'($urandom % 4);
    e = 2 * (256 - reload) * div;
    v = $urandom;
    wr(8'h99, v | 8'h01);
    for (k = 0; k < 2000 && tx !== 1'b0; k++)
      @(negedge ref_clk);
    for (k = 0; k < 2000 && tx === 1'b0; k++)
      @(negedge ref_clk);
    cmp_n("start bit cycles", e, k);
    // Let the rest of the frame drain before the next choice
    repeat (11 * e) @(negedge ref_clk);
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    v = $urandom(32'he727a4ab);
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    rd(8'h98, v);
    cmp("ctrl reset", 8'h40, v);
    rd(8'h97, v);
    cmp("unmapped", 8'h00, v);
    // Fill the buffer while the timer is stopped
    n = 0;
    while (rdy === 1'b1 && n < 12) begin
      v = $urandom;
      wr(8'h99, v);
      exp_q.push_back(v);
      n++;
    end
    // Eight queued words plus one held by the idle shifter
    cmp("fill", 8'h09, 8'(n));
    timer_run = 1'b1;
    heard(n);
    while (exp_q.size() > 0 && peer.got_q.size() > 0)
      cmp("tx byte", exp_q.pop_front(), 8'(peer.got_q.pop_front()));
    rd(8'h98, v);
    cmp("ctrl tx done", 8'h42, v);
    cmp("irq", 8'h01, {7'h00, irq});
    irq_en = 1'b0;
    repeat (2) @(negedge ref_clk);
    cmp("irq masked", 8'h00, {7'h00, irq});
    irq_en = 1'b1;
    // Receive, then overrun with the buffer unread
    wr(8'h98, 8'h10);
    b0 = $urandom;
    peer.send({1'b0, b0}, 1'b1);
    rd(8'h98, v);
    cmp("ctrl rx done", 8'h55, v);
    peer.send({1'b0, ~b0}, 1'b1);
    rd(8'h99, v);
    cmp("rx byte", b0, v);
    // Bad stop bit with the check on
    wr(8'h98, 8'h30);
    peer.send({1'b0, ~b0}, 1'b0);
    rd(8'h98, v);
    cmp("ctrl bad stop", 8'h70, v);
    // Nine-bit frames with the address filter on
    nine = 1'b1;
    wr(8'h98, 8'hb8);
    v = $urandom;
    wr(8'h99, v);
    heard(1);
    w = peer.got_q.pop_front();
    cmp("tx ninth", {v[6:0], 1'b1}, {w[6:0], w[8]});
    cmp("tx nine byte", v, w[7:0]);
    peer.send({1'b0, b0}, 1'b1);
    rd(8'h98, v);
    cmp("ctrl filtered", 8'hfa, v);
    peer.send({1'b1, b0}, 1'b1);
    rd(8'h98, v);
    cmp("ctrl addr", 8'hff, v);
    rd(8'h99, v);
    cmp("rx addr byte", b0, v);
    // Every timer input choice but the undivided one, each with a fresh reload byte
    bit_time(3'h1, 4);
    bit_time(3'h2, 12);
    bit_time(3'h3, 48);
    // Eight oscillator edges, one every other cycle
    bit_time(3'h4, 16);
    print_verdict;
  end
endmodule
bind serial_port serial_port_chk chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
  .timer_run(timer_run), .port_int_enable(port_int_enable),
  .port_irq_r(port_irq_r), .tx_pin_r(tx_pin_r),
  .tx_buf_ready(tx_buf_ready));
